// *** hdl/hfa_fifo_access.sv ***
// HDLC FIFO host access: AHB-Lite registers, both FIFOs, line serializer.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module hfa_fifo_access
    import hfa_pkg::*;
#(
    parameter int unsigned TX_DEPTH = 256,
    parameter int unsigned RX_DEPTH = 256
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Receive bit stream from the HDLC engine, destuffed
    input  wire logic        rx_frame_start,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_abort,
    input  wire logic        rx_crc_bad,
    // Transmit line side and receive FIFO overrun
    input  wire logic        tx_bit_en,
    output logic             tx_line_bit,
    output logic             tx_packet_done,
    output logic             tx_underrun,
    output logic             rx_overrun
);
    localparam int unsigned TAW = $clog2(TX_DEPTH);
    localparam int unsigned RAW = $clog2(RX_DEPTH);

    generate
        if (TX_DEPTH < 16 || (1 << TAW) != TX_DEPTH ||
            RX_DEPTH < 2 || (1 << RAW) != RX_DEPTH) begin : g_bad
            $error("FIFO depths must be powers of two, transmit at least 16");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Bus slave. Every transfer takes one wait state so that read data
    // comes from a flop; the side effect of a tag read lands with it.
    // ------------------------------------------------------------------
    logic        dph_r;
    logic        dph_wr_r;
    logic [7:0]  dph_idx_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic        acc;
    logic        rd_info;
    logic        rd_rx_data;
    logic        rd_rx_tag;
    logic        wr_tx_data;
    logic        wr_tx_mark;

    assign acc = hsel && htrans[1] && hready;
    assign rd_info    = dph_r && !dph_wr_r && dph_idx_r == IDX_FIFO_INFO;
    assign rd_rx_data = dph_r && !dph_wr_r && dph_idx_r == IDX_RX_DATA;
    assign rd_rx_tag  = dph_r && !dph_wr_r && dph_idx_r == IDX_RX_TAG;
    assign wr_tx_data = dph_r && dph_wr_r && dph_idx_r == IDX_TX_DATA;
    assign wr_tx_mark = dph_r && dph_wr_r && dph_idx_r == IDX_TX_MARKER;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_r       <= 1'b0;
            dph_wr_r    <= 1'b0;
            dph_idx_r   <= 8'h00;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else if (acc) begin
            dph_r       <= 1'b1;
            dph_wr_r    <= hwrite;
            dph_idx_r   <= haddr[IDX_MSB:IDX_LSB];
            hreadyout_r <= 1'b0;
        end else begin
            dph_r       <= 1'b0;
            hreadyout_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Transmit FIFO.
    // ------------------------------------------------------------------
    hfa_tx_entry_t tx_mem [TX_DEPTH];
    logic [TAW-1:0] tx_wr_ptr_r;
    logic [TAW-1:0] tx_rd_ptr_r;
    logic [TAW:0]   tx_cnt_r;
    logic [7:0]     tx_hold_r;
    logic           tx_full;
    logic           tx_empty;
    logic           tx_push;
    logic           tx_pop;
    hfa_tx_entry_t  tx_head;

    assign tx_full  = tx_cnt_r == (TAW + 1)'(TX_DEPTH);
    assign tx_empty = tx_cnt_r == '0;
    assign tx_push  = wr_tx_mark && !tx_full;
    assign tx_head  = tx_mem[tx_rd_ptr_r];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hold_r <= TX_DATA_RST;
        end else if (wr_tx_data) begin
            tx_hold_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk) begin
        if (tx_push) begin
            tx_mem[tx_wr_ptr_r] <= '{tx_message_last: hwdata[MARKER_BIT],
                                     data: tx_hold_r};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wr_ptr_r <= '0;
            tx_rd_ptr_r <= '0;
            tx_cnt_r    <= '0;
        end else begin
            if (tx_push) begin
                tx_wr_ptr_r <= tx_wr_ptr_r + 1'b1;
            end
            if (tx_pop) begin
                tx_rd_ptr_r <= tx_rd_ptr_r + 1'b1;
            end
            if (tx_push && !tx_pop) begin
                tx_cnt_r <= tx_cnt_r + 1'b1;
            end else if (tx_pop && !tx_push) begin
                tx_cnt_r <= tx_cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive FIFO and byte assembly.
    // ------------------------------------------------------------------
    hfa_rx_entry_t rx_mem [RX_DEPTH];
    logic [RAW-1:0] rx_wr_ptr_r;
    logic [RAW-1:0] rx_rd_ptr_r;
    logic [RAW:0]   rx_cnt_r;
    logic           rx_full;
    logic           rx_empty;
    logic           rx_pop;
    logic           rx_push;
    hfa_rx_entry_t  rx_entry;
    hfa_rx_entry_t  rx_head;
    logic [7:0]     rx_sh_r;
    logic [2:0]     rx_bits_r;
    logic [2:0]     rx_bytes_r;
    logic [7:0]     pend_data_r;
    logic           pend_valid_r;
    logic           pend_open_r;
    logic           byte_done;
    logic [7:0]     new_byte;
    logic [1:0]     end_result;

    assign rx_full  = rx_cnt_r == (RAW + 1)'(RX_DEPTH);
    assign rx_empty = rx_cnt_r == '0;
    assign rx_pop   = rd_rx_tag && !rx_empty;
    assign rx_head  = rx_mem[rx_rd_ptr_r];
    // A new bit enters at the top, so the first bit ends up in bit 0.
    assign new_byte  = {rx_bit, rx_sh_r[7:1]};
    assign byte_done = rx_bit_valid && !rx_frame_end && rx_bits_r == 3'h7;

    always_comb begin
        if (rx_abort) begin
            end_result = PR_ABORT;
        end else if (rx_bytes_r < SHORT_LEN || rx_bits_r != 3'h0) begin
            end_result = PR_SHORT;
        end else if (rx_crc_bad) begin
            end_result = PR_CRC_ERR;
        end else begin
            end_result = PR_VALID;
        end
    end

    // The last byte of a packet is only known at the frame end, so each
    // byte waits in a one-entry stage until its successor or the end.
    always_comb begin
        rx_push  = 1'b0;
        rx_entry = '{packet_result: PR_VALID, closing_byte_tag: 1'b0,
                     opening_byte_tag: pend_open_r, data: pend_data_r};
        if (rx_frame_end && pend_valid_r) begin
            rx_push = 1'b1;
            rx_entry.closing_byte_tag = 1'b1;
            rx_entry.packet_result = end_result;
        end else if (byte_done && pend_valid_r) begin
            rx_push = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sh_r      <= 8'h00;
            rx_bits_r    <= 3'h0;
            rx_bytes_r   <= 3'h0;
            pend_data_r  <= 8'h00;
            pend_valid_r <= 1'b0;
            pend_open_r  <= 1'b0;
        end else if (rx_frame_start || rx_frame_end) begin
            rx_bits_r    <= 3'h0;
            rx_bytes_r   <= 3'h0;
            pend_valid_r <= 1'b0;
        end else if (rx_bit_valid) begin
            rx_sh_r   <= new_byte;
            rx_bits_r <= rx_bits_r + 3'h1;
            if (byte_done) begin
                pend_data_r  <= new_byte;
                pend_valid_r <= 1'b1;
                pend_open_r  <= rx_bytes_r == 3'h0;
                if (rx_bytes_r != SHORT_LEN) begin
                    rx_bytes_r <= rx_bytes_r + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (rx_push && !rx_full) begin
            rx_mem[rx_wr_ptr_r] <= rx_entry;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_wr_ptr_r <= '0;
            rx_rd_ptr_r <= '0;
            rx_cnt_r    <= '0;
            rx_overrun  <= 1'b0;
        end else begin
            rx_overrun <= rx_push && rx_full;
            if (rx_push && !rx_full) begin
                rx_wr_ptr_r <= rx_wr_ptr_r + 1'b1;
            end
            if (rx_pop) begin
                rx_rd_ptr_r <= rx_rd_ptr_r + 1'b1;
            end
            if (rx_push && !rx_full && !rx_pop) begin
                rx_cnt_r <= rx_cnt_r + 1'b1;
            end else if (rx_pop && !(rx_push && !rx_full)) begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Information register and read data. Only status, no interrupt
    // source exists in this block at all.
    // ------------------------------------------------------------------
    logic [7:0] info_r;
    logic [3:0] level;
    logic [TAW:0] tx_steps;

    assign tx_steps = tx_cnt_r >> LEVEL_STEP_LOG2;
    assign level = tx_steps > (TAW + 1)'(LEVEL_MAX) ? LEVEL_MAX
                                                    : tx_steps[3:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            info_r <= 8'h30;
        end else begin
            info_r <= 8'h00;
            info_r[INFO_LEVEL_LSB +: 4]  <= level;
            info_r[INFO_TX_EMPTY_BIT]    <= tx_empty;
            info_r[INFO_RX_EMPTY_BIT]    <= rx_empty;
        end
    end

    // Transmit registers and unmapped addresses read back as zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (dph_r && !dph_wr_r) begin
            hrdata_r <= 32'h0000_0000;
            if (rd_info) begin
                hrdata_r[7:0] <= info_r;
            end else if (rd_rx_data) begin
                hrdata_r[7:0] <= rx_head.data;
            end else if (rd_rx_tag && !rx_empty) begin
                hrdata_r[3:0] <= rx_head[11:8];
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;

    // ------------------------------------------------------------------
    // Transmit serializer with zero insertion, CRC and closing flags.
    // ------------------------------------------------------------------
    hfa_txs_t    txs_r;
    logic [15:0] sh_r;
    logic [3:0]  bit_cnt_r;
    logic [2:0]  ones_r;
    logic [1:0]  flags_r;
    logic        cur_last_r;
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic        stuff;
    logic        unit_end;
    logic        step;
    logic        want_data;

    // Not gated by state: a CRC that ends in five ones still needs its
    // zero before the closing flag, or the far end sees an abort.
    assign stuff    = ones_r == STUFF_ONES;
    assign step     = tx_bit_en && !stuff;
    assign unit_end = txs_r == TXS_CRC ? bit_cnt_r == 4'hF
                                       : bit_cnt_r == 4'h7;
    assign want_data = (txs_r == TXS_FLAG && flags_r >= MIN_FLAGS - 2'h1) ||
                       (txs_r == TXS_DATA && !cur_last_r);
    assign tx_pop   = step && unit_end && want_data && !tx_empty;
    assign crc_nxt  = (crc_r >> 1) ^
                      ((crc_r[0] ^ sh_r[0]) ? CRC_POLY : 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_r <= CRC_INIT;
        end else if (step && txs_r == TXS_FLAG) begin
            crc_r <= CRC_INIT;
        end else if (step && txs_r == TXS_DATA) begin
            crc_r <= crc_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txs_r          <= TXS_FLAG;
            sh_r           <= {8'h00, FLAG_BYTE};
            bit_cnt_r      <= 4'h0;
            ones_r         <= 3'h0;
            flags_r        <= 2'h0;
            cur_last_r     <= 1'b0;
            tx_line_bit    <= 1'b1;
            tx_packet_done <= 1'b0;
            tx_underrun    <= 1'b0;
        end else begin
            tx_packet_done <= 1'b0;
            tx_underrun    <= 1'b0;
            if (tx_bit_en && stuff) begin
                tx_line_bit <= 1'b0;
                ones_r      <= 3'h0;
            end else if (step) begin
                tx_line_bit <= sh_r[0];
                ones_r      <= (txs_r != TXS_FLAG && sh_r[0]) ?
                               ones_r + 3'h1 : 3'h0;
                sh_r        <= sh_r >> 1;
                bit_cnt_r   <= bit_cnt_r + 4'h1;
                if (unit_end) begin
                    bit_cnt_r <= 4'h0;
                    case (txs_r)
                        TXS_FLAG: begin
                            sh_r <= {8'h00, FLAG_BYTE};
                            if (flags_r != MIN_FLAGS) begin
                                flags_r <= flags_r + 2'h1;
                            end
                            if (tx_pop) begin
                                txs_r      <= TXS_DATA;
                                sh_r       <= {8'h00, tx_head.data};
                                cur_last_r <= tx_head.tx_message_last;
                                tx_packet_done <=
                                    tx_head.tx_message_last;
                            end
                        end
                        TXS_DATA: begin
                            if (cur_last_r) begin
                                txs_r <= TXS_CRC;
                                sh_r  <= ~crc_nxt;
                            end else if (tx_pop) begin
                                sh_r       <= {8'h00, tx_head.data};
                                cur_last_r <= tx_head.tx_message_last;
                                tx_packet_done <=
                                    tx_head.tx_message_last;
                            end else begin
                                // Underrun: the packet is dropped and the
                                // line falls back to flags at once.
                                txs_r          <= TXS_FLAG;
                                sh_r           <= {8'h00, FLAG_BYTE};
                                flags_r        <= 2'h0;
                                tx_packet_done <= 1'b1;
                                tx_underrun    <= 1'b1;
                            end
                        end
                        TXS_CRC: begin
                            txs_r   <= TXS_FLAG;
                            sh_r    <= {8'h00, FLAG_BYTE};
                            flags_r <= 2'h0;
                        end
                        default: begin
                            txs_r <= TXS_FLAG;
                            sh_r  <= {8'h00, FLAG_BYTE};
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    level_code_a: assert property ($past(hresetn) |-> info_r[3:0] ==
        (($past(tx_cnt_r) >> 4) > 15 ? 4'hF : 4'($past(tx_cnt_r) >> 4)))
        else $error("transmit level code wrong");
    tx_empty_flag_a: assert property ($past(hresetn) |->
        info_r[INFO_TX_EMPTY_BIT] == ($past(tx_cnt_r) == '0))
        else $error("transmit empty flag wrong");
    rx_empty_flag_a: assert property ($past(hresetn) |->
        info_r[INFO_RX_EMPTY_BIT] == ($past(rx_cnt_r) == '0))
        else $error("receive empty flag wrong");
    tag_read_pop_a: assert property (rd_rx_tag && !rx_empty |=>
        rx_rd_ptr_r == $past(rx_rd_ptr_r) + 1'b1)
        else $error("tag read did not advance");
    data_read_hold_a: assert property (rd_rx_data |=>
        rx_rd_ptr_r == $past(rx_rd_ptr_r) && hrdata[7:0] == $past(rx_head.data))
        else $error("data read moved pointer or wrong byte");
    empty_tag_read_a: assert property (rd_rx_tag && rx_empty |=>
        $stable(rx_rd_ptr_r) && $stable(rx_cnt_r))
        else $error("empty tag read changed state");
    marker_push_a: assert property (wr_tx_mark && !tx_full |=>
        tx_wr_ptr_r == $past(tx_wr_ptr_r) + 1'b1 &&
        tx_mem[$past(tx_wr_ptr_r)].data == $past(tx_hold_r))
        else $error("marker write did not push");
    full_drop_a: assert property (wr_tx_mark && tx_full |=>
        $stable(tx_wr_ptr_r))
        else $error("write stored while full");
    short_result_a: assert property (rx_push && rx_entry.closing_byte_tag &&
        !rx_abort && rx_bytes_r < SHORT_LEN |->
        rx_entry.packet_result == PR_SHORT)
        else $error("short packet not flagged");
    crc_follows_a: assert property (step && unit_end && txs_r == TXS_DATA &&
        cur_last_r |=> txs_r == TXS_CRC ##0 bit_cnt_r == 4'h0)
        else $error("CRC did not follow end byte");

    cover_tag_pop_c: cover property (rd_rx_tag && !rx_empty);
    cover_tx_full_c: cover property (wr_tx_mark && tx_full);
    cover_crc_c: cover property (txs_r == TXS_CRC ##1 txs_r == TXS_FLAG);
    cover_underrun_c: cover property (tx_underrun);
endmodule
`default_nettype wire

// *** pkg/hfa_pkg.sv ***
// Shared constants and types for the HDLC FIFO host access block.
package hfa_pkg;
    // Register indices; the byte address of each is four times its index.
    localparam logic [7:0]  IDX_FIFO_INFO     = 8'h57;
    localparam logic [7:0]  IDX_RX_DATA       = 8'h5C;
    localparam logic [7:0]  IDX_RX_TAG        = 8'h5D;
    localparam logic [7:0]  IDX_TX_DATA       = 8'h5E;
    localparam logic [7:0]  IDX_TX_MARKER     = 8'h5F;
    localparam int unsigned IDX_LSB           = 2;
    localparam int unsigned IDX_MSB           = 9;
    // Field positions.
    localparam int unsigned INFO_LEVEL_LSB    = 0;
    localparam int unsigned INFO_TX_EMPTY_BIT = 4;
    localparam int unsigned INFO_RX_EMPTY_BIT = 5;
    localparam int unsigned MARKER_BIT        = 0;
    localparam int unsigned LEVEL_STEP_LOG2   = 4;
    localparam logic [3:0]  LEVEL_MAX         = 4'hF;
    // Reset values.
    localparam logic [7:0]  TX_DATA_RST       = 8'h00;
    // Packet result codes.
    localparam logic [1:0]  PR_VALID          = 2'h0;
    localparam logic [1:0]  PR_CRC_ERR        = 2'h1;
    localparam logic [1:0]  PR_SHORT          = 2'h2;
    localparam logic [1:0]  PR_ABORT          = 2'h3;
    localparam logic [2:0]  SHORT_LEN         = 3'h4;
    // Line framing.
    localparam logic [7:0]  FLAG_BYTE         = 8'h7E;
    localparam logic [15:0] CRC_INIT          = 16'hFFFF;
    localparam logic [15:0] CRC_POLY          = 16'h8408;
    localparam logic [1:0]  MIN_FLAGS         = 2'h2;
    localparam logic [2:0]  STUFF_ONES        = 3'h5;

    typedef struct packed {
        logic [1:0] packet_result;
        logic       closing_byte_tag;
        logic       opening_byte_tag;
        logic [7:0] data;
    } hfa_rx_entry_t;

    typedef struct packed {
        logic       tx_message_last;
        logic [7:0] data;
    } hfa_tx_entry_t;

    typedef enum logic [2:0] {
        TXS_FLAG = 3'b001,
        TXS_DATA = 3'b010,
        TXS_CRC  = 3'b100
    } hfa_txs_t;
endpackage

// *** testbench/hfa_line_model.sv ***
// Line-side model: feeds destuffed receive frames and paces bit slots.
`timescale 1ns/100ps
`default_nettype none
module hfa_line_model
    import hfa_pkg::*;
(
    // Clock
    input  wire logic hclk,
    // Receive stream and transmit pacing
    output logic      rx_frame_start,
    output logic      rx_bit_valid,
    output logic      rx_bit,
    output logic      rx_frame_end,
    output logic      rx_abort,
    output logic      rx_crc_bad,
    output logic      tx_bit_en
);
    logic run = 1'b0;
    initial begin
        {rx_frame_start, rx_bit_valid, rx_bit, rx_frame_end} = '0;
        {rx_abort, rx_crc_bad, tx_bit_en} = '0;
    end
    // Slots stay off until the bench lets the transmit FIFO drain.
    always @(posedge hclk) tx_bit_en <= run && !tx_bit_en;
    task automatic frame(input logic [7:0] b[$], input logic [1:0] r);
        @(posedge hclk) rx_frame_start <= 1'b1;
        foreach (b[i]) for (int k = 0; k < 8; k++) begin
            @(posedge hclk) rx_frame_start <= 1'b0;
            rx_bit_valid <= 1'b1;
            rx_bit <= b[i][k];
        end
        @(posedge hclk) rx_bit_valid <= 1'b0;
        rx_frame_end <= 1'b1;
        rx_abort <= r == PR_ABORT;
        rx_crc_bad <= r == PR_CRC_ERR;
        // An idle data line shows the inverse, never a held value.
        @(posedge hclk) rx_bit <= ~rx_bit;
        {rx_frame_end, rx_abort, rx_crc_bad} <= '0;
    endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the HDLC FIFO host access block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import hfa_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = '0;
    logic        hreadyout, rd_ph = 1'b0, cl, tpd, tund, tline, hrsp, rovr;
    logic        rfs, rbv, rb, rfe, rab, rcb, tben;
    logic [15:0] exp_q[$], e;
    logic [7:0]  q[$], tx_q[$], sr = '0;
    int          n_mismatch = 0, n_compared = 0, n_done = 0, n_und = 0, n;
    int          n_ovr = 0;
    int unsigned lens[5] = '{5, 6, 4, 1, 3};
    logic [1:0]  rin[5] = '{PR_CRC_ERR, PR_ABORT, PR_VALID, PR_VALID,
                            PR_CRC_ERR};
    logic [1:0]  rex[5] = '{PR_CRC_ERR, PR_ABORT, PR_VALID, PR_SHORT,
                            PR_SHORT};
    always #12.5 hclk = ~hclk;
    hfa_fifo_access dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hrsp), .rx_frame_start(rfs),
        .rx_bit_valid(rbv), .rx_bit(rb), .rx_frame_end(rfe),
        .rx_abort(rab), .rx_crc_bad(rcb), .tx_bit_en(tben),
        .tx_line_bit(tline), .tx_packet_done(tpd), .tx_underrun(tund),
        .rx_overrun(rovr));
    hfa_line_model line_u (.hclk(hclk), .rx_frame_start(rfs),
        .rx_bit_valid(rbv), .rx_bit(rb), .rx_frame_end(rfe),
        .rx_abort(rab), .rx_crc_bad(rcb), .tx_bit_en(tben));
    task automatic chk(input string w, input logic [7:0] s, x);
        n_compared++;
        if (s !== x) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", w, x, s);
        end
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic [7:0] idx, input logic w,
                       input logic [7:0] d);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    // Masked bits are those the register leaves undefined.
    task automatic rd(input logic [7:0] idx, m, x);
        exp_q.push_back({m, x});
        bus(idx, 1'b0, 8'($urandom));
    endtask
    always @(posedge hclk) begin
        n_done += int'(tpd);
        n_und += int'(tund);
        n_ovr += int'(rovr);
        // A line bit settles in the cycle after its slot, so it is taken
        // while the slot enable is low.
        if (!tben) sr <= {tline, sr[7:1]};
        if (tund)
            chk("line byte", {tline, sr[7:1]}, tx_q.pop_front());
        if (rd_ph && hreadyout) begin
            e = exp_q.pop_front();
            chk("hresp", 8'(hrsp), 8'h00);
            chk("hrdata", hrdata[7:0] & e[15:8], e[7:0] & e[15:8]);
        end
        if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(66807));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(IDX_FIFO_INFO, 8'h3F, 8'h30);
        rd(IDX_TX_DATA, 8'hFF, 8'h00);
        rd(IDX_TX_MARKER, 8'hFF, 8'h00);
        rd(8'h50, 8'hFF, 8'h00);
        rd(IDX_RX_TAG, 8'hFF, 8'h00);
        for (int f = 0; f < 5; f++) begin
            q = {};
            repeat (lens[f]) q.push_back(8'($urandom));
            line_u.frame(q, rin[f]);
            rd(IDX_FIFO_INFO, 8'h20, 8'h00);
            foreach (q[i]) begin
                rd(IDX_RX_DATA, 8'hFF, q[i]);
                rd(IDX_RX_DATA, 8'hFF, q[i]);
                cl = i == lens[f] - 1;
                rd(IDX_RX_TAG, cl ? 8'h0F : 8'h03,
                   {4'h0, rex[f], cl, i == 0});
            end
            rd(IDX_FIFO_INFO, 8'h20, 8'h20);
        end
        for (int i = 1; i <= 257; i++) begin
            bus(IDX_TX_DATA, 1'b1, 8'($urandom));
            bus(IDX_TX_MARKER, 1'b1, {7'h0, i >= 256});
            n = i > 256 ? 256 : i;
            if (i inside {1, 15, 16, 240, 256, 257})
                rd(IDX_FIFO_INFO, 8'h3F,
                   {4'h2, n >= 240 ? LEVEL_MAX : 4'(n >> 4)});
        end
        line_u.run <= 1'b1;
        repeat (9000) if (n_done == 0) @(posedge hclk);
        rd(IDX_FIFO_INFO, 8'h3F, 8'h30);
        repeat (200) @(posedge hclk);
        chk("packet done", 8'(n_done), 8'h01);
        chk("underrun", 8'(n_und), 8'h00);
        // A lone unmarked byte starves the serializer; bit 4 is kept clear
        // so that no zero is inserted into it on the line.
        tx_q.push_back(8'($urandom) & 8'hEF);
        bus(IDX_TX_DATA, 1'b1, tx_q[0]);
        bus(IDX_TX_MARKER, 1'b1, 8'h00);
        repeat (200) if (n_und == 0) @(posedge hclk);
        chk("underrun", 8'(n_und), 8'h01);
        chk("packet done", 8'(n_done), 8'h02);
        // Two bytes too many: the last two pushes are dropped.
        q = {};
        repeat (258) q.push_back(8'($urandom));
        line_u.frame(q, PR_VALID);
        rd(IDX_RX_DATA, 8'hFF, q[0]);
        chk("overrun", 8'(n_ovr), 8'h02);
        @(posedge hclk);
        conclude();
    end
endmodule
`default_nettype wire
